//--- core/led_status_pkg.sv
`default_nettype none
package led_status_pkg;
  // timing
  localparam int CLK_HZ = 200_000_000;
  localparam int PWM_HZ = 30_000;
  localparam int PWM_PERIOD_DEF = CLK_HZ / PWM_HZ;
  localparam int PWM_STEPS = 16;
  // bus geometry
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 12'h000;
  localparam logic [ADDR_W-1:0] STATUS_OFS = 12'h004;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // control word fields
  localparam int CTRL_MODE = 0;
  localparam int CTRL_FORCEV = 2;
  localparam int CTRL_TYPE = 3;
  localparam int CTRL_SENSE_VM = 4;
  localparam int CTRL_DIM = 5;
  localparam int CTRL_REVIND = 6;
  localparam int CTRL_INDEN = 7;
  localparam int CTRL_LEDCH = 8;
  localparam int CTRL_LEVEL = 12;
  localparam int CTRL_OVC = 16;
  localparam logic [31:0] CTRL_WMASK = 32'h000F_F7FF;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  // status word fields
  localparam int STAT_PG = 0;
  localparam int STAT_DOWN = 1;
  localparam int STAT_WARN = 2;
  localparam int STAT_HOT = 3;
  localparam int STAT_FAIL = 4;
  localparam int STAT_DIE = 5;
  localparam int STAT_OVPH = 7;
  localparam int STAT_DIM = 8;
  // operating modes
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_TORCH = 2'h1;
  localparam logic [1:0] MODE_FLASH = 2'h2;
  localparam logic [1:0] MODE_VOLT = 2'h3;
  localparam logic [1:0] DIE_TRIPPED = 2'h3;
  localparam logic [3:0] OVP_LOW_MAX = 4'h4;

  // comparator results from the analog side
  typedef struct packed {
    logic vin_ge_vout;
    logic vin_below_hyst;
    logic vout_in_window;
    logic reverse_recycle;
    logic therm_below_warn;
    logic therm_below_hot;
    logic ovp_limit_hit;
    logic vf_below_short;
  } cmp_t;
endpackage
`default_nettype wire

//--- core/led_status_protection.sv
// Behaviour
// - voltage mode: enter down mode when vin>=vout
// - leave down mode when vin 200mV below
// - power good only active in voltage mode
// - shutdown: pin grounded (type 0) or open (1)
// - push-pull follows flag; open-drain inverted
// - power good only inside output window
// - power good false when voltage mode off
// - power good false during reverse recycling
// - indicator current set by level code
// - reverse indicator only in shutdown
// - fixed 30kHz pwm from internal clock
// - pwm duty chosen by level code
// - dimming only torch with force bit, enabled leds
// - dimming disables torch watchdog
// - thermistor watched in torch/flash, volt needs enable
// - warm warning below 1.05V, keep running
// - latch overheat below 0.345V while regulating
// - overheat suspends, clears mode, sets die status
// - low ovp threshold for codes up to 0100
// - open led at ovp limit sets failure
// - forward voltage below 1.23V sets failure
// - short limits current to programmed level
`timescale 1ns/1ps
`default_nettype none
module led_status_protection
  import led_status_pkg::*;
#(
  parameter int PWM_PERIOD_CYC = PWM_PERIOD_DEF
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // axi4-lite read
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // analog comparator results, asynchronous
  input wire cmp_t cmp_raw,
  // general output pin, open-drain capable
  output logic general_output_pin_out,
  output logic general_output_pin_oe,
  // controls to the analog side
  output logic down_mode_en,
  output logic overvoltage_limit_high,
  output logic indicator_enable,
  output logic [3:0] indicator_level_code,
  output logic reverse_indicator_en,
  output logic [2:0] led_pwm_gate,
  output logic torch_watchdog_disable,
  output logic led_overheat_suspend,
  output logic short_current_limit
);

  localparam logic [12:0] PWM_LAST = 13'(PWM_PERIOD_CYC - 1);
  localparam logic [12:0] PWM_STEP = 13'(PWM_PERIOD_CYC / PWM_STEPS);

  // whole module state
  typedef struct packed {
    cmp_t s1;
    cmp_t s2;
    cmp_t s3;
    cmp_t filt;
    logic [31:0] ctrl;
    logic down;
    logic pg;
    logic warn;
    logic hot;
    logic fail;
    logic [1:0] die;
    logic [12:0] pwm_cnt;
    logic pwm_on;
    logic gpo_out;
    logic gpo_oe;
    logic ind_en;
    logic [3:0] ind_code;
    logic rev_ind;
    logic ovp_high;
    logic [2:0] led_gate;
    logic wd_dis;
    logic short_lim;
    logic awready;
    logic wready;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } state_t;

  state_t q;
  state_t n;
  logic [1:0] mode;
  logic force_vm;
  logic vm;
  logic shut;
  logic regl;
  logic therm_on;
  logic dim;
  logic [31:0] be_mask;
  logic [31:0] status_word;
  logic [12:0] duty;

  // byte-lane mask from the held strobes
  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_lane
      assign be_mask[8*g +: 8] = {8{q.wstrb[g]}};
    end
  endgenerate

  // status word as seen by software
  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[STAT_PG] = q.pg;
    status_word[STAT_DOWN] = q.down;
    status_word[STAT_WARN] = q.warn;
    status_word[STAT_HOT] = q.hot;
    status_word[STAT_FAIL] = q.fail;
    status_word[STAT_DIE +: 2] = q.die;
    status_word[STAT_OVPH] = q.ovp_high;
    status_word[STAT_DIM] = q.wd_dis;
  end

  // next state
  always_comb
  begin
    n = q;
    // three-stage synchroniser, change accepted when stages 2 and 3 agree
    n.s1 = cmp_raw;
    n.s2 = q.s1;
    n.s3 = q.s2;
    n.filt = cmp_t'((q.s2 & q.s3) | (q.filt & (q.s2 ^ q.s3)));
    // mode decode
    mode = q.ctrl[CTRL_MODE +: 2];
    force_vm = q.ctrl[CTRL_FORCEV];
    vm = (mode == MODE_VOLT) | force_vm;
    shut = (mode == MODE_OFF) & ~force_vm;
    regl = (mode == MODE_TORCH) | (mode == MODE_FLASH);
    therm_on = regl | ((mode == MODE_VOLT) & q.ctrl[CTRL_SENSE_VM]);
    dim = q.ctrl[CTRL_DIM] & (mode == MODE_TORCH) & force_vm;
    duty = 13'(q.ctrl[CTRL_LEVEL +: 4]) * PWM_STEP;

    // down conversion with hysteresis
    if (!vm)
      n.down = 1'b0;
    else if (q.filt.vin_ge_vout)
      n.down = 1'b1;
    else if (q.filt.vin_below_hyst)
      n.down = 1'b0;

    // power good: window, voltage mode, not recycling
    n.pg = vm & q.filt.vout_in_window & ~q.filt.reverse_recycle;

    // output pin drive
    if (shut)
    begin
      n.gpo_out = 1'b0;
      n.gpo_oe = ~q.ctrl[CTRL_TYPE];
    end
    else if (!q.ctrl[CTRL_TYPE])
    begin
      n.gpo_out = q.pg;
      n.gpo_oe = 1'b1;
    end
    else
    begin
      n.gpo_out = 1'b0;
      n.gpo_oe = q.pg;
    end

    // dedicated indicator
    n.ind_code = q.ctrl[CTRL_LEVEL +: 4];
    n.ind_en = q.ctrl[CTRL_INDEN] & ~dim;
    n.rev_ind = q.ctrl[CTRL_REVIND] & shut;

    // pwm dimming timebase
    if (!dim || q.pwm_cnt == PWM_LAST)
      n.pwm_cnt = 13'h0000;
    else
      n.pwm_cnt = q.pwm_cnt + 13'h0001;
    n.pwm_on = dim & (q.pwm_cnt < duty);
    n.led_gate = q.ctrl[CTRL_LEDCH +: 3] & (dim ? {3{q.pwm_on}} : 3'h7);
    n.wd_dis = dim;

    // protection levels
    n.warn = therm_on & q.filt.therm_below_warn;
    n.ovp_high = q.ctrl[CTRL_OVC +: 4] > OVP_LOW_MAX;
    n.short_lim = regl & q.filt.vf_below_short;

    // axi write address and data, either order
    if (awvalid && q.awready)
    begin
      n.awready = 1'b0;
      n.awaddr = awaddr;
    end
    if (wvalid && q.wready)
    begin
      n.wready = 1'b0;
      n.wdata = wdata;
      n.wstrb = wstrb;
    end
    if (!q.awready && !q.wready && !q.bvalid)
    begin
      n.bvalid = 1'b1;
      if (q.awaddr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2])
      begin
        n.ctrl = (q.ctrl & ~be_mask) | (q.wdata & be_mask & CTRL_WMASK);
        n.bresp = RESP_OKAY;
      end
      else if (q.awaddr[ADDR_W-1:2] == STATUS_OFS[ADDR_W-1:2])
        n.bresp = RESP_OKAY;
      else
        n.bresp = RESP_SLVERR;
    end
    if (q.bvalid && bready)
    begin
      n.bvalid = 1'b0;
      n.awready = 1'b1;
      n.wready = 1'b1;
    end

    // axi read; status read clears the fault latches
    if (arvalid && q.arready)
    begin
      n.arready = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      if (araddr[ADDR_W-1:2] == CTRL_OFS[ADDR_W-1:2])
        n.rdata = q.ctrl;
      else if (araddr[ADDR_W-1:2] == STATUS_OFS[ADDR_W-1:2])
      begin
        n.rdata = status_word;
        n.hot = 1'b0;
        n.fail = 1'b0;
        n.die = 2'h0;
      end
      else
      begin
        n.rdata = 32'h0000_0000;
        n.rresp = RESP_SLVERR;
      end
    end
    if (q.rvalid && rready)
    begin
      n.rvalid = 1'b0;
      n.arready = 1'b1;
    end

    // fault sets come last so they win over clears and writes
    if (regl && q.filt.therm_below_hot)
    begin
      n.hot = 1'b1;
      n.die = DIE_TRIPPED;
      n.ctrl[CTRL_MODE +: 2] = MODE_OFF;
    end
    if (regl && (q.filt.ovp_limit_hit || q.filt.vf_below_short))
      n.fail = 1'b1;
  end

  // state register
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      q <= '0;
      q.ctrl <= CTRL_RESET;
      q.awready <= 1'b1;
      q.wready <= 1'b1;
      q.arready <= 1'b1;
    end
    else
      q <= n;
  end

  // outputs straight from the state register
  assign awready = q.awready;
  assign wready = q.wready;
  assign bresp = q.bresp;
  assign bvalid = q.bvalid;
  assign arready = q.arready;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
  assign rvalid = q.rvalid;
  assign general_output_pin_out = q.gpo_out;
  assign general_output_pin_oe = q.gpo_oe;
  assign down_mode_en = q.down;
  assign overvoltage_limit_high = q.ovp_high;
  assign indicator_enable = q.ind_en;
  assign indicator_level_code = q.ind_code;
  assign reverse_indicator_en = q.rev_ind;
  assign led_pwm_gate = q.led_gate;
  assign torch_watchdog_disable = q.wd_dis;
  assign led_overheat_suspend = q.hot;
  assign short_current_limit = q.short_lim;

  // checks
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  down_entry_a: assert property (vm && q.filt.vin_ge_vout |=> q.down)
    else $error("down mode not entered");
  down_exit_a: assert property (
    q.down && !q.filt.vin_ge_vout && q.filt.vin_below_hyst |=> !q.down)
    else $error("down mode not left");
  pg_vm_only_a: assert property (q.pg |-> $past(vm))
    else $error("power good outside voltage mode");
  shut_pin_a: assert property (shut && !q.ctrl[CTRL_TYPE] |=> q.gpo_oe && !q.gpo_out)
    else $error("shutdown pin not grounded");
  od_polarity_a: assert property (
    !shut && q.ctrl[CTRL_TYPE] |=> q.gpo_oe == $past(q.pg) && !q.gpo_out)
    else $error("open-drain polarity wrong");
  pp_follow_a: assert property (
    !shut && !q.ctrl[CTRL_TYPE] |=> q.gpo_oe && q.gpo_out == $past(q.pg))
    else $error("push-pull pin not following power good");
  pg_window_a: assert property (vm && !q.filt.vout_in_window |=> !q.pg)
    else $error("power good outside window");
  pg_off_vm_a: assert property (!vm |=> !q.pg)
    else $error("power good with voltage mode off");
  pg_recycle_a: assert property (q.filt.reverse_recycle |=> !q.pg)
    else $error("power good during recycling");
  rev_ind_a: assert property (reverse_indicator_en |-> $past(shut))
    else $error("reverse indicator outside shutdown");
  pwm_wrap_a: assert property (
    dim && q.pwm_cnt == PWM_LAST ##1 dim |-> q.pwm_cnt == 13'h0000)
    else $error("pwm period wrong");
  pwm_range_a: assert property (q.pwm_cnt <= PWM_LAST)
    else $error("pwm counter past period end");
  wd_dim_a: assert property (q.pwm_on |-> q.wd_dis ##0 $past(dim))
    else $error("watchdog not disabled while dimming");
  hot_latch_a: assert property (
    regl && q.filt.therm_below_hot |=> q.hot && q.die == DIE_TRIPPED && mode == MODE_OFF)
    else $error("overheat not latched");
  ovp_sel_a: assert property (
    1'b1 |=> q.ovp_high == ($past(q.ctrl[CTRL_OVC +: 4]) > OVP_LOW_MAX))
    else $error("ovp threshold select wrong");
  open_fail_a: assert property (regl && q.filt.ovp_limit_hit |=> q.fail)
    else $error("open led not flagged");
  short_flag_a: assert property (regl && q.filt.vf_below_short |=> q.fail)
    else $error("short not flagged");
  short_lim_a: assert property (regl && q.filt.vf_below_short |=> q.short_lim)
    else $error("short current limit not applied");
  warn_level_a: assert property (therm_on && q.filt.therm_below_warn |=> q.warn)
    else $error("warm warning not set");
  sync_agree_a: assert property (
    $rose(q.filt.therm_below_hot)
    |-> $past(q.s2.therm_below_hot) && $past(q.s3.therm_below_hot))
    else $error("flag changed before synchroniser agreed");
  fault_sticky_a: assert property (q.fail && !(arvalid && q.arready) |=> q.fail)
    else $error("failure flag lost without read");

endmodule
`default_nettype wire

//--- verification/host_master.sv
`timescale 1ns/1ps
`default_nettype none
module host_master
  import led_status_pkg::*;
(
  // clock
  input wire logic aclk,
  // write channels
  output var logic [ADDR_W-1:0] awaddr,
  output var logic awvalid,
  input wire logic awready,
  output var logic [31:0] wdata,
  output var logic [3:0] wstrb,
  output var logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output var logic bready,
  // read channels
  output var logic [ADDR_W-1:0] araddr,
  output var logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output var logic rready
);
  // idle bus from time zero
  initial
  begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // one write; each channel released once taken
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [3:0] st,
    output logic [1:0] r);
    logic ad;
    logic dd;
    @(posedge aclk);
    {awaddr, wdata, wstrb} <= {a, d, st};
    {awvalid, wvalid, bready} <= 3'b111;
    ad = 1'b0;
    dd = 1'b0;
    while (!(ad && dd))
    begin
      @(posedge aclk);
      if (awready && !ad)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !dd)
      begin
        dd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask
  // one read; no latency assumed
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    {d, r} = {rdata, rresp};
    rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

//--- verification/tb_led_status_protection.sv
`timescale 1ns/1ps
`default_nettype none
module tb_led_status_protection
  import led_status_pkg::*;
;
  localparam int PER = 32;
  logic aclk;
  logic aresetn;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, s;
  logic [3:0] wstrb, ind_code;
  logic [1:0] bresp, rresp, r;
  logic oe, out, down, ovh, ind_en, rev_en, wdog_dis, hot_sus, short_lim;
  logic [2:0] gate;
  cmp_t cmp;
  int error_cnt;
  int n_tests;

  // 200 MHz clock
  initial
  begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  led_status_protection #(.PWM_PERIOD_CYC(PER)) DUT (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .cmp_raw(cmp),
    .general_output_pin_out(out), .general_output_pin_oe(oe), .down_mode_en(down),
    .overvoltage_limit_high(ovh), .indicator_enable(ind_en), .indicator_level_code(ind_code),
    .reverse_indicator_en(rev_en), .led_pwm_gate(gate), .torch_watchdog_disable(wdog_dis),
    .led_overheat_suspend(hot_sus), .short_current_limit(short_lim));

  host_master host (
    .aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));

  // compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // control write, then let pin and outputs settle
  task automatic wc(input logic [31:0] v);
    host.wr(CTRL_OFS, v, 4'hF, r);
    repeat (4) @(posedge aclk);
  endtask
  // comparator levels, held past the synchroniser
  task automatic setc(input logic [7:0] c);
    cmp <= cmp_t'(c);
    repeat (10) @(posedge aclk);
  endtask
  task automatic rs;
    host.rd(STATUS_OFS, s, r);
  endtask

  task automatic t_bus;
    host.rd(CTRL_OFS, s, r);
    chk(s, CTRL_RESET);
    chk({oe, out}, 2'b10);
    host.rd(12'h100, s, r);
    chk(r, RESP_SLVERR);
    chk(s, 32'h0000_0000);
    host.wr(12'h100, 32'hFFFF_FFFF, 4'hF, r);
    chk(r, RESP_SLVERR);
    host.wr(STATUS_OFS, 32'hFFFF_FFFF, 4'hF, r);
    chk(r, RESP_OKAY);
    wc(32'hFFF0_0800);
    host.rd(CTRL_OFS, s, r);
    chk(s, 32'h0000_0000);
    // one byte lane only; reserved bits stay clear
    host.wr(CTRL_OFS, 32'hFFFF_FFFF, 4'h2, r);
    host.rd(CTRL_OFS, s, r);
    chk(s, CTRL_WMASK & 32'h0000_FF00);
    wc(32'h0000_0000);
  endtask
  task automatic t_pg;
    wc(32'h0000_0003);
    setc(8'h20);
    rs();
    chk(s[0], 1'b1);
    chk({oe, out}, 2'b11);
    wc(32'h0000_000B);
    chk({oe, out}, 2'b10);
    setc(8'h00);
    rs();
    chk({s[0], oe}, 2'b00);
    setc(8'h30);
    rs();
    chk(s[0], 1'b0);
    setc(8'h20);
    wc(32'h0000_0001);
    rs();
    chk(s[0], 1'b0);
    wc(32'h0000_0004);
    rs();
    chk(s[0], 1'b1);
    wc(32'h0000_0008);
    chk(oe, 1'b0);
    wc(32'h0000_0000);
    chk({oe, out}, 2'b10);
    setc(8'h00);
  endtask
  task automatic t_down;
    wc(32'h0000_0003);
    setc(8'h80);
    chk(down, 1'b1);
    setc(8'h00);
    chk(down, 1'b1);
    setc(8'h40);
    chk(down, 1'b0);
    setc(8'h00);
  endtask
  task automatic t_ovp;
    for (int i = 0; i < 16; i++)
    begin
      wc({12'h000, i[3:0], 16'h0000});
      chk(ovh, i > 4);
    end
  endtask
  task automatic t_ind;
    wc(32'h0000_90C0);
    chk({ind_en, ind_code, rev_en}, 6'b1_1001_1);
    wc(32'h0000_90C3);
    chk(rev_en, 1'b0);
  endtask
  task automatic t_dim;
    int n;
    int m;
    wc(32'h0000_8525);
    n = 0;
    m = 0;
    repeat (2 * PER)
    begin
      @(posedge aclk);
      n += gate[0];
      m += gate[1];
    end
    chk(n, 2 * 8 * (PER / 16));
    chk(m, 0);
    rs();
    chk({wdog_dis, s[8]}, 2'b11);
    wc(32'h0000_8521);
    rs();
    chk({wdog_dis, s[8]}, 2'b00);
  endtask
  task automatic t_temp;
    wc(32'h0000_0001);
    setc(8'h08);
    rs();
    chk(s[2], 1'b1);
    host.rd(CTRL_OFS, s, r);
    chk(s[1:0], MODE_TORCH);
    wc(32'h0000_0003);
    rs();
    chk(s[2], 1'b0);
    wc(32'h0000_0013);
    rs();
    chk(s[2], 1'b1);
    wc(32'h0000_0001);
    setc(8'h0C);
    chk(hot_sus, 1'b1);
    setc(8'h00);
    host.rd(CTRL_OFS, s, r);
    chk(s[1:0], MODE_OFF);
    rs();
    chk(s[6:3], 4'b1101);
    rs();
    chk(s[6:3], 4'b0000);
  endtask
  task automatic t_fail;
    wc(32'h0000_0002);
    setc(8'h02);
    setc(8'h00);
    rs();
    chk(s[4], 1'b1);
    rs();
    chk(s[4], 1'b0);
    wc(32'h0000_0001);
    cmp <= cmp_t'(8'h01);
    repeat (2) @(posedge aclk);
    chk(short_lim, 1'b0);
    repeat (8) @(posedge aclk);
    chk(short_lim, 1'b1);
    rs();
    chk(s[4], 1'b1);
    setc(8'h00);
  endtask

  // verdict and end of run
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // whole run needs well under 10k cycles; 40k cuts a hang
  initial
  begin
    #200_000;
    error_cnt++;
    stop_test();
  end

  // reset for three cycles, then the scenarios
  initial
  begin
    error_cnt = 0;
    n_tests = 0;
    aresetn = 1'b0;
    cmp = '0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_bus();
    t_pg();
    t_down();
    t_ovp();
    t_ind();
    t_dim();
    t_temp();
    t_fail();
    stop_test();
  end
endmodule
`default_nettype wire
